// [bench/tb_top.sv]
/*
  self-checking bench of the status and debug register bank.
  assumes tsd_pkg, tsd_regs, tsd_core_model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
  localparam logic [31:0] RAM_B = 32'h0002_0000;
  typedef struct packed {
    logic w; logic d; logic [7:0] idx; logic [31:0] wd; logic [31:0] ex;
  } tsd_row_type;
  localparam tsd_row_type ROWS [17] = '{
    '{1'b1, 1'b0, 8'h06, 32'hffff_ffff, 32'h0000_0003},
    '{1'b1, 1'b0, 8'h06, 32'h0000_0000, 32'h0000_0000},
    '{1'b1, 1'b1, 8'h11, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
    '{1'b1, 1'b1, 8'h12, 32'h1234_5678, 32'h1234_5678},
    '{1'b1, 1'b1, 8'h13, 32'hffff_ffff, 32'h0000_00ff},
    '{1'b1, 1'b1, 8'h14, 32'hffff_ffff, 32'h0000_001f},
    '{1'b1, 1'b1, 8'h15, 32'hffff_ffff, 32'h0003_ff07},
    '{1'b1, 1'b1, 8'h16, 32'hdead_beef, 32'hdead_beef},
    '{1'b1, 1'b1, 8'h18, 32'hffff_ffff, 32'h0000_00ff},
    '{1'b1, 1'b0, 8'h18, 32'h0000_0000, 32'h0000_00ff},
    '{1'b1, 1'b1, 8'h20, 32'h0bad_f00d, 32'h0bad_f00d},
    '{1'b1, 1'b1, 8'h27, 32'h1357_9bdf, 32'h1357_9bdf},
    '{1'b1, 1'b1, 8'h30, 32'h0000_a000, 32'h0000_a000},
    '{1'b1, 1'b1, 8'h33, 32'hffff_0004, 32'hffff_0004},
    '{1'b1, 1'b1, 8'h40, 32'hffff_ffff, 32'h00ff_0003},
    '{1'b1, 1'b1, 8'h0c, 32'hffff_ffff, RAM_B},
    '{1'b1, 1'b1, 8'h0b, 32'hffff_ffff, 32'h0000_0000}};
  localparam logic [2:0] CODES [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
  logic                    clock, rst_n, req_valid, ack, cfg_valid, cfg_write, cfg_ack;
  logic                    exec_valid, debug_return, debug_enter, debug_mode;
  logic [2:0]              cfg_index, exec_thread;
  logic [3:0]              osc_tick;
  logic [7:0]              thread_stop, rr_thread;
  logic [4:0]              rr_regnum;
  logic [31:0]             rdata, cfg_wdata, cfg_rdata, exec_pc, rd, a, exp_data;
  tsd_pkg::tsd_req_type    req;
  tsd_pkg::tsd_event_type  ext_event, ev;
  tsd_pkg::tsd_thread_type thread_state;
  int                      failures, n_tests, cycles;
  ////////////////////////////////////////////////////////////
  tsd_regs #(.RAM_BYTES(RAM_B)) i_tsd_regs (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .ack(ack), .rdata(rdata), .cfg_valid(cfg_valid),
    .cfg_write(cfg_write), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .osc_tick(osc_tick), .ext_event(ext_event),
    .exec_valid(exec_valid), .exec_thread(exec_thread), .exec_pc(exec_pc),
    .thread_state(thread_state), .debug_return(debug_return), .debug_enter(debug_enter),
    .debug_mode(debug_mode), .thread_stop(thread_stop),
    .remote_register_read_thread(rr_thread), .remote_register_read_regnum(rr_regnum));
  tsd_core_model i_tsd_core_model (.clock(clock), .rst_n(rst_n), .osc_tick(osc_tick),
    .thread_state(thread_state));
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic d, input logic [7:0] ix,
                     input logic [31:0] wd, output logic [31:0] r);
    req_valid <= 1'b1;
    req <= '{w, d, ix, wd};
    @(posedge clock);
    req_valid <= 1'b0;
    @(posedge clock);
    r = rdata;
    `CHK("ack", 1'b1, ack)
  endtask
  task automatic cfg(input logic w, input logic [2:0] ix, input logic [31:0] wd,
                     output logic [31:0] r);
    cfg_valid <= 1'b1;
    cfg_write <= w;
    cfg_index <= ix;
    cfg_wdata <= wd;
    @(posedge clock);
    cfg_valid <= 1'b0;
    @(posedge clock);
    r = cfg_rdata;
  endtask
  task automatic issue(input logic [2:0] th, input logic [31:0] pc, input logic hit);
    exec_valid <= 1'b1;
    exec_thread <= th;
    exec_pc <= pc;
    @(posedge clock);
    exec_valid <= 1'b0;
    @(posedge clock);
    `CHK("break entry", hit, debug_enter)
  endtask
  task automatic leave();
    debug_return <= 1'b1;
    @(posedge clock);
    debug_return <= 1'b0;
    @(posedge clock);
    `CHK("mode after return", 1'b0, debug_mode)
    `CHK("stop mask", 8'hff, thread_stop)
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0; req_valid = 1'b0; req = '0; cfg_valid = 1'b0; cfg_write = 1'b0;
    cfg_index = 3'h0; cfg_wdata = 32'h0; ext_event = '0; exec_valid = 1'b0;
    exec_thread = 3'h0; exec_pc = 32'h0; debug_return = 1'b0; exp_data = 32'hdead_beef;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, 1'b1, tsd_pkg::IDX_OSC_CTRL, 32'h0, rd);
    `CHK("osc ctrl reset", 32'h0, rd)
    bus(1'b0, 1'b1, tsd_pkg::IDX_CAUSE, 32'h0, rd);
    `CHK("cause reset", 3'h0, rd[2:0])
    foreach (ROWS[i]) begin
      bus(ROWS[i].w, ROWS[i].d, ROWS[i].idx, ROWS[i].wd, rd);
      bus(1'b0, 1'b1, ROWS[i].idx, 32'h0, rd);
      `CHK("readback", ROWS[i].ex, rd)
    end
    `CHK("remote thread", 8'hff, rr_thread)
    `CHK("remote regnum", 5'h1f, rr_regnum)
    // breakpoints 1 and 2 on the same address, thread 0 only
    bus(1'b1, 1'b1, 8'h40, 32'h0, rd);
    bus(1'b1, 1'b1, 8'h43, 32'h0, rd);
    bus(1'b1, 1'b1, 8'h31, 32'h0000_1000, rd);
    bus(1'b1, 1'b1, 8'h32, 32'h0000_1000, rd);
    bus(1'b1, 1'b1, 8'h41, 32'h0001_0001, rd);
    bus(1'b1, 1'b1, 8'h42, 32'h0001_0001, rd);
    issue(3'h1, 32'h0000_1000, 1'b0);
    issue(3'h0, 32'h0000_1000, 1'b1);
    bus(1'b0, 1'b1, tsd_pkg::IDX_CAUSE, 32'h0, rd);
    `CHK("break cause", 32'h0001_0003, rd)
    bus(1'b0, 1'b1, tsd_pkg::IDX_PC, 32'h0, rd);
    `CHK("saved pc", 32'h0000_4a4c, rd)
    bus(1'b0, 1'b1, tsd_pkg::IDX_SP, 32'h0, rd);
    `CHK("saved sp", 32'h0001_fff0, rd)
    bus(1'b0, 1'b1, tsd_pkg::IDX_STATUS, 32'h0, rd);
    `CHK("saved status", 32'h0000_07df, rd)
    bus(1'b1, 1'b1, tsd_pkg::IDX_STATUS, 32'hffff_fe20, rd);
    bus(1'b0, 1'b1, tsd_pkg::IDX_STATUS, 32'h0, rd);
    `CHK("status write", 32'h0000_0700, rd)
    leave();
    bus(1'b1, 1'b1, 8'h41, 32'h0001_0003, rd);
    issue(3'h0, 32'h0000_2000, 1'b1);
    bus(1'b0, 1'b1, tsd_pkg::IDX_CAUSE, 32'h0, rd);
    `CHK("inequality cause", 32'h0001_0003, rd)
    leave();
    bus(1'b1, 1'b1, 8'h41, 32'h0, rd);
    bus(1'b1, 1'b1, 8'h42, 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      ev = '{1'b1, CODES[i], 8'h03, 4'h6, 32'h0c0d_e0e0 + 32'(i)};
      if (CODES[i] >= 3'h4) exp_data = ev.data;
      ext_event <= ev;
      @(posedge clock);
      ext_event <= '0;
      @(posedge clock);
      `CHK("event entry", 1'b1, debug_enter)
      bus(1'b0, 1'b1, tsd_pkg::IDX_CAUSE, 32'h0, rd);
      `CHK("event cause", {14'h0, 2'(CODES[i] >= 3'h4), (CODES[i] == 3'h1) ? 8'h00 : 8'h03,
                           5'h0, CODES[i]}, rd)
      bus(1'b0, 1'b1, tsd_pkg::IDX_CAUSE_DATA, 32'h0, rd);
      `CHK("event data", exp_data, rd)
      leave();
    end
    cfg(1'b1, 3'h5, 32'h2468_ace0, rd);
    bus(1'b0, 1'b1, 8'h25, 32'h0, rd);
    `CHK("shared scratch", 32'h2468_ace0, rd)
    bus(1'b1, 1'b1, 8'h20, 32'h1111_2222, rd);
    cfg(1'b0, 3'h0, 32'h0, rd);
    `CHK("config scratch", 32'h1111_2222, rd)
    // run the core rings, stop them, let them settle before reading
    bus(1'b1, 1'b0, tsd_pkg::IDX_OSC_CTRL, 32'h0000_0002, rd);
    repeat (20) @(posedge clock);
    bus(1'b1, 1'b0, tsd_pkg::IDX_OSC_CTRL, 32'h0, rd);
    repeat (10) @(posedge clock);
    bus(1'b0, 1'b0, tsd_pkg::IDX_OSC_BASE, 32'h0, a);
    `CHK("count reserved", 16'h0, a[31:16])
    `CHK("count advanced", 1'b1, a[15:0] != 16'h0000)
    repeat (5) @(posedge clock);
    bus(1'b0, 1'b0, tsd_pkg::IDX_OSC_BASE, 32'h0, rd);
    `CHK("stopped count", a, rd)
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, 1'b0, tsd_pkg::IDX_OSC_BASE, 32'h0, rd);
    `CHK("count over reset", a, rd)
    tally_and_finish();
  end
endmodule // tb_top
bind tsd_regs tsd_regs_props #(.RAM_BYTES(RAM_BYTES)) i_tsd_regs_props (.clock(clock),
  .rst_n(rst_n), .req_valid(req_valid), .req(req), .ack(ack), .rdata(rdata),
  .cfg_valid(cfg_valid), .cfg_ack(cfg_ack), .ext_event(ext_event),
  .debug_return(debug_return), .debug_enter(debug_enter), .debug_mode(debug_mode),
  .thread_stop(thread_stop), .remote_register_read_thread(remote_register_read_thread));
`default_nettype wire

// [bench/tsd_core_model.sv]
/*
  model of the tile side: ring oscillator ticks and thread state.
  assumes the bank samples thread_state on debugger entry.
*/
`timescale 1ns/1ps
`default_nettype none
module tsd_core_model #(
  parameter logic [10:0] STATUS = 11'h7ff,
  parameter logic [31:0] PC     = 32'h0000_4a4c,
  parameter logic [31:0] SP     = 32'h0001_fff0
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  output var  logic [3:0]              osc_tick,
  output var  tsd_pkg::tsd_thread_type thread_state
);
  logic [1:0] phase;
  // rings tick from a phase count of clock, at half or a quarter of the core rate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase    <= 2'h0;
      osc_tick <= 4'h0;
    end else begin
      phase    <= phase + 2'h1;
      osc_tick <= {phase[0], phase == 2'h1, phase[1], phase == 2'h3};
    end
  end
  assign thread_state = '{STATUS, PC, SP};
endmodule // tsd_core_model
`default_nettype wire

// [bench/tsd_regs_properties.sv]
/*
  port checker of the tile status and debug register bank.
  assumes a bind from the bench top file and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tsd_regs_props #(
  parameter logic [31:0] RAM_BYTES = 32'h0008_0000
) (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   req_valid,
  input wire tsd_pkg::tsd_req_type   req,
  input wire logic                   ack,
  input wire logic [31:0]            rdata,
  input wire logic                   cfg_valid,
  input wire logic                   cfg_ack,
  input wire tsd_pkg::tsd_event_type ext_event,
  input wire logic                   debug_return,
  input wire logic                   debug_enter,
  input wire logic                   debug_mode,
  input wire logic [7:0]             thread_stop,
  input wire logic [7:0]             remote_register_read_thread
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  a_mem_size_value: assert property (
    req_valid && !req.write && req.index == tsd_pkg::IDX_MEM_SIZE
    |=> ack && rdata == {RAM_BYTES[31:2], 2'h0}) else $error("memory size read wrong");
  a_osc_ctrl_reserved: assert property (
    req_valid && !req.write && req.index == tsd_pkg::IDX_OSC_CTRL
    |=> rdata[31:2] == 30'h0) else $error("oscillator control reserved bits set");
  a_host_entry: assert property (
    !debug_mode && ext_event.valid && ext_event.cause == tsd_pkg::CAUSE_HOST
    |=> debug_enter && debug_mode) else $error("host request did not enter debug");
  a_enter_single: assert property (debug_enter |=> !debug_enter)
    else $error("entry pulse too long");
  a_stop_zero_dbg: assert property (debug_mode |-> thread_stop == 8'h00)
    else $error("threads stopped inside debug mode");
  a_no_reentry: assert property (debug_mode |=> !debug_enter)
    else $error("entry taken while in debug mode");
  a_return_leaves: assert property (debug_mode && debug_return |=> !debug_mode)
    else $error("debug mode not left");
  a_remote_thread: assert property (
    req_valid && req.write && req.debug && req.index == tsd_pkg::IDX_RD_THREAD
    |-> ##2 remote_register_read_thread == $past(req.wdata[7:0], 2))
    else $error("remote read thread not copied");
  a_cfg_ack_follows: assert property (cfg_valid |=> cfg_ack)
    else $error("config access not acknowledged");
endmodule // tsd_regs_props
`default_nettype wire

// [hw/tsd_pkg.sv]
/*
  constants and carrier types of the tile status and debug register bank.
  assumes a single core clock domain; no imports, all uses are scoped.
*/
`default_nettype none
package tsd_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_OSC = 4;
  localparam int NUM_BRK = 4;
  localparam int NUM_SCRATCH = 8;
  localparam int NUM_THREADS = 8;
  // register indices
  localparam logic [7:0] IDX_OSC_CTRL = 8'h06;
  localparam logic [7:0] IDX_OSC_BASE = 8'h07;
  localparam logic [7:0] IDX_MEM_SIZE = 8'h0c;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_PC = 8'h11;
  localparam logic [7:0] IDX_SP = 8'h12;
  localparam logic [7:0] IDX_RD_THREAD = 8'h13;
  localparam logic [7:0] IDX_RD_REGNUM = 8'h14;
  localparam logic [7:0] IDX_CAUSE = 8'h15;
  localparam logic [7:0] IDX_CAUSE_DATA = 8'h16;
  localparam logic [7:0] IDX_STOP_MASK = 8'h18;
  localparam logic [7:0] IDX_SCRATCH = 8'h20;
  localparam logic [7:0] IDX_BRK_ADDR = 8'h30;
  localparam logic [7:0] IDX_BRK_CTRL = 8'h40;
  // field positions and masks
  localparam int OSC_CORE_BIT = 1;
  localparam int OSC_PERIPH_BIT = 0;
  localparam logic [31:0] OSC_CTRL_MASK = 32'h0000_0003;
  localparam logic [31:0] STATUS_MASK = 32'h0000_07df;
  localparam logic [31:0] STATUS_WR_MASK = 32'h0000_06df;
  localparam logic [31:0] CAUSE_MASK = 32'h0003_ff07;
  localparam logic [31:0] BRK_CTRL_MASK = 32'h00ff_0003;
  localparam int BRK_ARM_BIT = 0;
  localparam int BRK_NEQ_BIT = 1;
  localparam int BRK_THR_LSB = 16;
  // cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_HOST = 3'h1;
  localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2;
  localparam logic [2:0] CAUSE_IBREAK = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;
  // least stop time before a counter read, in core clocks
  localparam int OSC_SETTLE_CYCLES = 10;

  typedef struct packed {
    logic        write;
    logic        debug;
    logic [7:0]  index;
    logic [31:0] wdata;
  } tsd_req_type;

  typedef struct packed {
    logic        valid;
    logic [2:0]  cause;
    logic [7:0]  thread;
    logic [3:0]  hits;
    logic [31:0] data;
  } tsd_event_type;

  typedef struct packed {
    logic [10:0] status;
    logic [31:0] pc;
    logic [31:0] sp;
  } tsd_thread_type;
endpackage
`default_nettype wire

// [hw/tsd_regs.sv]
/*
  processor-status and debug register bank of one tile.
  assumes requests from the status instructions and the debugger, the
  oscillator ticks and the thread state all arrive synchronous to clock.
*/
// Functional notes
// - four oscillator counters, control at 0x06
// - bit1 core, bit0 peripheral enable, reset 0
// - four 16-bit counts at 0x07 onward
// - counter values survive reset
// - oscillators asynchronous, usable as random bits
// - memory size in bits 31:2 at 0x0c
// - capture thread status word on debugger entry
// - capture pc and sp on entry
// - remote read thread 7:0, register 4:0
// - cause code 1..5 in bits 2:0
// - breakpoint index, lowest wins, zero otherwise
// - causing thread in 15:8, zero for host
// - data register takes address or resource id
// - stop mask keeps marked threads from running outside debug mode
// - eight scratch words shared with config space
// - four breakpoint addresses matched against pc
// - arm bit, inequality bit, per-thread enables
`timescale 1ns/1ps
`default_nettype none
module tsd_regs #(
  parameter logic [31:0] RAM_BYTES = 32'h0008_0000
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   req_valid,
  input  wire tsd_pkg::tsd_req_type   req,
  output var  logic                   ack,
  output var  logic [31:0]            rdata,
  input  wire logic                   cfg_valid,
  input  wire logic                   cfg_write,
  input  wire logic [2:0]             cfg_index,
  input  wire logic [31:0]            cfg_wdata,
  output var  logic                   cfg_ack,
  output var  logic [31:0]            cfg_rdata,
  input  wire logic [3:0]             osc_tick,
  input  wire tsd_pkg::tsd_event_type ext_event,
  input  wire logic                   exec_valid,
  input  wire logic [2:0]             exec_thread,
  input  wire logic [31:0]            exec_pc,
  input  wire tsd_pkg::tsd_thread_type thread_state,
  input  wire logic                   debug_return,
  output var  logic                   debug_enter,
  output var  logic                   debug_mode,
  output var  logic [7:0]             thread_stop,
  output var  logic [7:0]             remote_register_read_thread,
  output var  logic [4:0]             remote_register_read_regnum
);

  initial begin
    if (RAM_BYTES[1:0] != 2'h0) begin
      $error("tsd_regs: RAM_BYTES must be a multiple of four");
    end
  end

  ////////////////////////////////////////////////////////////////////
  // request decode
  logic wr;
  logic dbg_wr;
  assign wr = req_valid && req.write;
  assign dbg_wr = wr && req.debug;

  logic [1:0]  osc_ctrl;
  // power-on zero; system reset leaves the counts alone
  logic [15:0] osc_count [tsd_pkg::NUM_OSC] = '{default: 16'h0000};
  logic [10:0] saved_status_word;
  logic [31:0] saved_pc;
  logic [31:0] saved_sp;
  logic [7:0]  rd_thread;
  logic [4:0]  rd_regnum;
  logic [31:0] cause_reg;
  logic [31:0] cause_data;
  logic [7:0]  stop_mask;
  logic [31:0] scratch [tsd_pkg::NUM_SCRATCH];
  logic [31:0] brk_addr [tsd_pkg::NUM_BRK];
  logic [31:0] brk_ctrl [tsd_pkg::NUM_BRK];

  ////////////////////////////////////////////////////////////////////
  // oscillator control
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_ctrl <= 2'h0;
    end else if (wr && req.index == tsd_pkg::IDX_OSC_CTRL) begin
      osc_ctrl <= req.wdata[1:0];
    end
  end

  // counters are never reset; ticks come from free-running rings
  logic [3:0] osc_run;
  assign osc_run = {osc_ctrl[tsd_pkg::OSC_PERIPH_BIT], osc_ctrl[tsd_pkg::OSC_PERIPH_BIT],
                    osc_ctrl[tsd_pkg::OSC_CORE_BIT], osc_ctrl[tsd_pkg::OSC_CORE_BIT]};

  genvar g;
  generate
    for (g = 0; g < tsd_pkg::NUM_OSC; g = g + 1) begin : g_osc
      always_ff @(posedge clock) begin
        if (osc_run[g] && osc_tick[g]) begin
          osc_count[g] <= osc_count[g] + 16'h0001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // instruction breakpoints
  logic [3:0] brk_hit;
  always_comb begin
    for (int i = 0; i < tsd_pkg::NUM_BRK; i++) begin
      brk_hit[i] = exec_valid && !debug_mode
        && brk_ctrl[i][tsd_pkg::BRK_ARM_BIT]
        && brk_ctrl[i][tsd_pkg::BRK_THR_LSB + 32'(exec_thread)]
        && ((exec_pc == brk_addr[i]) != brk_ctrl[i][tsd_pkg::BRK_NEQ_BIT]);
    end
  end

  // lowest numbered hit wins
  function automatic logic [1:0] lowest(input logic [3:0] hits);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = tsd_pkg::NUM_BRK - 1; i >= 0; i--) begin
      if (hits[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // debug entry resolution
  logic        entry;
  logic [2:0]  entry_cause;
  logic [7:0]  entry_thread;
  logic [1:0]  entry_index;
  logic [31:0] entry_data;

  always_comb begin
    entry = 1'b0;
    entry_cause = tsd_pkg::CAUSE_NONE;
    entry_thread = 8'h00;
    entry_index = 2'h0;
    entry_data = cause_data;
    if (!debug_mode) begin
      if (ext_event.valid && ext_event.cause == tsd_pkg::CAUSE_HOST) begin
        entry = 1'b1;
        entry_cause = tsd_pkg::CAUSE_HOST;
      end else if (ext_event.valid && ext_event.cause == tsd_pkg::CAUSE_DEBUG_CALL_INSTRUCTION) begin
        entry = 1'b1;
        entry_cause = tsd_pkg::CAUSE_DEBUG_CALL_INSTRUCTION;
        entry_thread = ext_event.thread;
      end else if (|brk_hit) begin
        entry = 1'b1;
        entry_cause = tsd_pkg::CAUSE_IBREAK;
        entry_thread = {5'h00, exec_thread};
        entry_index = lowest(brk_hit);
      end else if (ext_event.valid && (ext_event.cause == tsd_pkg::CAUSE_DWATCH
                   || ext_event.cause == tsd_pkg::CAUSE_RWATCH)) begin
        entry = 1'b1;
        entry_cause = ext_event.cause;
        entry_thread = ext_event.thread;
        entry_index = lowest(ext_event.hits);
        entry_data = ext_event.data;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      debug_mode <= 1'b0;
      debug_enter <= 1'b0;
    end else begin
      debug_enter <= entry;
      if (entry) begin
        debug_mode <= 1'b1;
      end else if (debug_return) begin
        debug_mode <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // captured thread state; capture beats a debugger write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      saved_status_word <= 11'h000;
      saved_pc <= 32'h0000_0000;
      saved_sp <= 32'h0000_0000;
    end else if (entry) begin
      saved_status_word <= thread_state.status & tsd_pkg::STATUS_MASK[10:0];
      saved_pc <= thread_state.pc;
      saved_sp <= thread_state.sp;
    end else if (dbg_wr) begin
      if (req.index == tsd_pkg::IDX_STATUS) begin
        saved_status_word <= (saved_status_word & ~tsd_pkg::STATUS_WR_MASK[10:0])
                           | (req.wdata[10:0] & tsd_pkg::STATUS_WR_MASK[10:0]);
      end else if (req.index == tsd_pkg::IDX_PC) begin
        saved_pc <= req.wdata;
      end else if (req.index == tsd_pkg::IDX_SP) begin
        saved_sp <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // cause and cause data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= 32'h0000_0000;
      cause_data <= 32'h0000_0000;
    end else if (entry) begin
      cause_reg <= {14'h0000, entry_index, entry_thread, 5'h00, entry_cause};
      cause_data <= entry_data;
    end else if (dbg_wr) begin
      if (req.index == tsd_pkg::IDX_CAUSE) begin
        cause_reg <= req.wdata & tsd_pkg::CAUSE_MASK;
      end else if (req.index == tsd_pkg::IDX_CAUSE_DATA) begin
        cause_data <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // remote read operands and stop mask
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_thread <= 8'h00;
      rd_regnum <= 5'h00;
    end else if (dbg_wr) begin
      if (req.index == tsd_pkg::IDX_RD_THREAD) begin
        rd_thread <= req.wdata[7:0];
      end else if (req.index == tsd_pkg::IDX_RD_REGNUM) begin
        rd_regnum <= req.wdata[4:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stop_mask <= 8'h00;
    end else if (dbg_wr && req.index == tsd_pkg::IDX_STOP_MASK) begin
      stop_mask <= req.wdata[7:0];
    end
  end

  // marked threads are held only outside debug mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      thread_stop <= 8'h00;
    end else if (entry || (debug_mode && !debug_return)) begin
      thread_stop <= 8'h00;
    end else begin
      thread_stop <= stop_mask;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      remote_register_read_thread <= 8'h00;
      remote_register_read_regnum <= 5'h00;
    end else begin
      remote_register_read_thread <= rd_thread;
      remote_register_read_regnum <= rd_regnum;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // scratch words, reachable from both spaces; status side wins a tie
  logic [7:0] scr_off;
  assign scr_off = req.index - tsd_pkg::IDX_SCRATCH;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < tsd_pkg::NUM_SCRATCH; i++) begin
        scratch[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < tsd_pkg::NUM_SCRATCH; i++) begin
        if (dbg_wr && scr_off == 8'(i)) begin
          scratch[i] <= req.wdata;
        end else if (cfg_valid && cfg_write && cfg_index == 3'(i)) begin
          scratch[i] <= cfg_wdata;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= cfg_valid;
      if (cfg_valid && !cfg_write) begin
        cfg_rdata <= scratch[cfg_index];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // breakpoint address and control words
  logic [7:0] ba_off;
  logic [7:0] bc_off;
  assign ba_off = req.index - tsd_pkg::IDX_BRK_ADDR;
  assign bc_off = req.index - tsd_pkg::IDX_BRK_CTRL;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < tsd_pkg::NUM_BRK; i++) begin
        brk_addr[i] <= 32'h0000_0000;
        brk_ctrl[i] <= 32'h0000_0000;
      end
    end else if (dbg_wr) begin
      for (int i = 0; i < tsd_pkg::NUM_BRK; i++) begin
        if (ba_off == 8'(i)) begin
          brk_addr[i] <= req.wdata;
        end
        if (bc_off == 8'(i)) begin
          brk_ctrl[i] <= req.wdata & tsd_pkg::BRK_CTRL_MASK;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] next_rdata;
  logic [7:0]  osc_off;
  assign osc_off = req.index - tsd_pkg::IDX_OSC_BASE;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (req.index == tsd_pkg::IDX_OSC_CTRL) begin
      next_rdata = {30'h0, osc_ctrl};
    end else if (req.index >= tsd_pkg::IDX_OSC_BASE && osc_off < 8'(tsd_pkg::NUM_OSC)) begin
      next_rdata = {16'h0000, osc_count[osc_off[1:0]]};
    end else if (req.index == tsd_pkg::IDX_MEM_SIZE) begin
      next_rdata = {RAM_BYTES[31:2], 2'h0};
    end else if (req.index == tsd_pkg::IDX_STATUS) begin
      next_rdata = {21'h0, saved_status_word};
    end else if (req.index == tsd_pkg::IDX_PC) begin
      next_rdata = saved_pc;
    end else if (req.index == tsd_pkg::IDX_SP) begin
      next_rdata = saved_sp;
    end else if (req.index == tsd_pkg::IDX_RD_THREAD) begin
      next_rdata = {24'h0, rd_thread};
    end else if (req.index == tsd_pkg::IDX_RD_REGNUM) begin
      next_rdata = {27'h0, rd_regnum};
    end else if (req.index == tsd_pkg::IDX_CAUSE) begin
      next_rdata = cause_reg;
    end else if (req.index == tsd_pkg::IDX_CAUSE_DATA) begin
      next_rdata = cause_data;
    end else if (req.index == tsd_pkg::IDX_STOP_MASK) begin
      next_rdata = {24'h0, stop_mask};
    end else if (req.index >= tsd_pkg::IDX_SCRATCH
                 && scr_off < 8'(tsd_pkg::NUM_SCRATCH)) begin
      next_rdata = scratch[scr_off[2:0]];
    end else if (req.index >= tsd_pkg::IDX_BRK_ADDR && ba_off < 8'(tsd_pkg::NUM_BRK)) begin
      next_rdata = brk_addr[ba_off[1:0]];
    end else if (req.index >= tsd_pkg::IDX_BRK_CTRL && bc_off < 8'(tsd_pkg::NUM_BRK)) begin
      next_rdata = brk_ctrl[bc_off[1:0]];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= req_valid;
      if (req_valid && !req.write) begin
        rdata <= next_rdata;
      end
    end
  end

endmodule // tsd_regs
`default_nettype wire
